// *** verilog/rcar_pkg.sv ***
// calendar and alarm register block: shared offsets, ranges and codings
// assumes an 8-bit i/o address space with the block decoded at its fixed offsets
package rcar_pkg;

  // ------------------------------------------------------------
  // register offsets on the i/o bus
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_WEEKDAY = 8'he3;
  localparam logic [7:0] OFS_MONTH_DAY = 8'he4;
  localparam logic [7:0] OFS_PERIOD = 8'he5;
  localparam logic [7:0] OFS_YEAR = 8'he6;
  localparam logic [7:0] OFS_HUNDRED = 8'he7;
  localparam logic [7:0] OFS_ALM_SEC = 8'he8;
  localparam logic [7:0] OFS_ALM_MIN = 8'he9;
  localparam logic [7:0] OFS_ALM_HOUR = 8'hea;

  // ------------------------------------------------------------
  // field layout and bus answers
  // ------------------------------------------------------------
  localparam int WEEKDAY_W = 4;
  localparam logic [3:0] RESERVED_NIBBLE = 4'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] MATCH_RESET = 8'h00;

  // ------------------------------------------------------------
  // legal ranges, in binary; bcd forms come from rcar_to_bcd
  // ------------------------------------------------------------
  localparam logic [7:0] WEEKDAY_LO = 8'h01;
  localparam logic [7:0] WEEKDAY_HI = 8'h07;
  localparam logic [7:0] MONTH_DAY_LO = 8'h01;
  localparam logic [7:0] MONTH_DAY_HI = 8'h1f;
  localparam logic [7:0] PERIOD_LO = 8'h01;
  localparam logic [7:0] PERIOD_HI = 8'h0c;
  localparam logic [7:0] YEAR_LO = 8'h00;
  localparam logic [7:0] YEAR_HI = 8'h63;
  localparam logic [3:0] BCD_ONES_MAX = 4'h9;

  // alarm enable bit positions
  localparam int EN_SEC = 0;
  localparam int EN_MIN = 1;
  localparam int EN_HOUR = 2;
  localparam int EN_WEEKDAY = 3;

  // binary value below 100 to packed bcd, tens in the upper nibble
  function automatic logic [7:0] rcar_to_bcd(input logic [7:0] bin);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = bin / 8'd10;
    ones = bin % 8'd10;
    return {tens[3:0], ones[3:0]};
  endfunction

endpackage

// *** verilog/rcar_step.sv ***
// one calendar digit pair: next value and wrap flag for a count in either coding
// assumes the current value is in range; values above the top wrap, values below the bottom simply count on
`timescale 1ns/1ps
`default_nettype none
module rcar_step import rcar_pkg::*; #(
  parameter logic [7:0] LO_BIN = 8'h00,
  parameter logic [7:0] HI_BIN = 8'h63
) (
  input wire logic [7:0] cur_in,
  input wire logic bcd_in,
  output logic [7:0] nxt_out,
  output logic wrap_out
);

  logic [7:0] lo_c;
  logic [7:0] hi_c;
  logic [3:0] tens_up;

  // ------------------------------------------------------------
  // range limits in the active coding
  // ------------------------------------------------------------
  assign lo_c = bcd_in ? rcar_to_bcd(LO_BIN) : LO_BIN;
  assign hi_c = bcd_in ? rcar_to_bcd(HI_BIN) : HI_BIN;
  assign tens_up = cur_in[7:4] + 4'h1;
  // a stray value above the top also wraps, so a bad write cannot run away
  assign wrap_out = (cur_in >= hi_c);

  // bcd carries ones into tens at nine; binary just adds one
  always_comb begin
    if (wrap_out) begin
      nxt_out = lo_c;
    end else if (bcd_in && (cur_in[3:0] >= BCD_ONES_MAX)) begin
      nxt_out = {tens_up, 4'h0};
    end else begin
      nxt_out = cur_in + 8'h01;
    end
  end

endmodule
`default_nettype wire

// *** verilog/rcar_match.sv ***
// alarm comparator: set-points against current counts, masked by enables
// assumes both sides are held in the same coding
`timescale 1ns/1ps
`default_nettype none
module rcar_match import rcar_pkg::*; (
  input wire logic [3:0] enable_in,
  input wire logic [7:0] sec_now_in,
  input wire logic [7:0] sec_set_in,
  input wire logic [7:0] min_now_in,
  input wire logic [7:0] min_set_in,
  input wire logic [7:0] hour_now_in,
  input wire logic [7:0] hour_set_in,
  input wire logic [3:0] weekday_now_in,
  input wire logic [3:0] weekday_set_in,
  output logic hit_out
);

  logic [3:0] equal;

  // ------------------------------------------------------------
  // a disabled field always agrees; nothing enabled means no alarm
  // ------------------------------------------------------------
  assign equal[EN_SEC] = (sec_now_in == sec_set_in) || !enable_in[EN_SEC];
  assign equal[EN_MIN] = (min_now_in == min_set_in) || !enable_in[EN_MIN];
  assign equal[EN_HOUR] = (hour_now_in == hour_set_in) || !enable_in[EN_HOUR];
  assign equal[EN_WEEKDAY] = (weekday_now_in == weekday_set_in) || !enable_in[EN_WEEKDAY];
  assign hit_out = (&equal) && (|enable_in);

endmodule
`default_nettype wire

// *** verilog/rcar_top.sv ***
// calendar counts and alarm set-points of the real-time clock, on the i/o bus
// assumes time-of-day counters, control bits and alarm enables live outside
// and share clk_in; their ticks are one-cycle pulses on that clock
//
// Summary of operation
// - weekday in low nibble, upper reads zero
// - weekday, day, month count from one
// - reset leaves counts and set-points alone
// - counts writable only while unlocked
// - binary or packed bcd per coding bit
// - month day 1..31, tens 0..3
// - month 1..12, tens 0..1
// - year 0..99, both digits decimal
// - century 0..99, both digits decimal
// - alarm seconds 0..59; code stores any written byte
// - alarm minutes 0..59; code stores any written byte
// - alarm hours 0..23; code stores any written byte
// - alarm set-points writable at any time
// - unlocked calendar stops counting
// - alarm only when all enabled fields match
// - compare on each one-second increment
`timescale 1ns/1ps
`default_nettype none
module rcar_top import rcar_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [7:0] io_rdata_out,
  input wire logic count_unlock_in,
  input wire logic bcd_mode_in,
  input wire logic day_roll_in,
  input wire logic second_tick_in,
  input wire logic force_compare_in,
  input wire logic [3:0] alarm_enable_in,
  input wire logic [7:0] cur_second_in,
  input wire logic [7:0] cur_minute_in,
  input wire logic [7:0] cur_hour_in,
  input wire logic [3:0] alarm_weekday_in,
  output logic alarm_match_out
);

  // ------------------------------------------------------------
  // storage: deliberately no reset on any of these
  // ------------------------------------------------------------
  logic [WEEKDAY_W-1:0] weekday_count;
  logic [7:0] day_of_month_count;
  logic [7:0] period_of_year_count;
  logic [7:0] year_count;
  logic [7:0] hundred_year_count;
  logic [7:0] alarm_second_value;
  logic [7:0] alarm_minute_value;
  logic [7:0] alarm_hour_value;

  logic [7:0] next_weekday;
  logic [7:0] next_month_day;
  logic [7:0] next_period;
  logic [7:0] next_year;
  logic [7:0] next_hundred;
  logic wrap_month_day;
  logic wrap_period;
  logic wrap_year;
  logic advance;
  logic count_wr;
  logic alarm_hit;
  logic [7:0] next_rdata;

  // ------------------------------------------------------------
  // counting and write enables
  // ------------------------------------------------------------
  // unlocked freezes calendar
  assign advance = day_roll_in && !count_unlock_in;
  assign count_wr = io_wr_in && count_unlock_in;

  // ------------------------------------------------------------
  // one step unit per count; the carries chain the cascade
  // ------------------------------------------------------------
  // weekday starts at one
  rcar_step #(
    .LO_BIN(WEEKDAY_LO),
    .HI_BIN(WEEKDAY_HI)
  ) u_weekday (
    .cur_in({RESERVED_NIBBLE, weekday_count}),
    .bcd_in(bcd_mode_in),
    .nxt_out(next_weekday),
    .wrap_out()
  );

  rcar_step #(
    .LO_BIN(MONTH_DAY_LO),
    .HI_BIN(MONTH_DAY_HI)
  ) u_month_day (
    .cur_in(day_of_month_count),
    .bcd_in(bcd_mode_in),
    .nxt_out(next_month_day),
    .wrap_out(wrap_month_day)
  );

  rcar_step #(
    .LO_BIN(PERIOD_LO),
    .HI_BIN(PERIOD_HI)
  ) u_period (
    .cur_in(period_of_year_count),
    .bcd_in(bcd_mode_in),
    .nxt_out(next_period),
    .wrap_out(wrap_period)
  );

  rcar_step #(
    .LO_BIN(YEAR_LO),
    .HI_BIN(YEAR_HI)
  ) u_year (
    .cur_in(year_count),
    .bcd_in(bcd_mode_in),
    .nxt_out(next_year),
    .wrap_out(wrap_year)
  );

  rcar_step #(
    .LO_BIN(YEAR_LO),
    .HI_BIN(YEAR_HI)
  ) u_hundred (
    .cur_in(hundred_year_count),
    .bcd_in(bcd_mode_in),
    .nxt_out(next_hundred),
    .wrap_out()
  );

  // ------------------------------------------------------------
  // calendar counts; write and advance never meet since one needs
  // the unlock and the other needs it clear
  // ------------------------------------------------------------
  // no reset on counts
  always_ff @(posedge clk_in) begin
    if (count_wr && (io_addr_in == OFS_WEEKDAY)) begin
      weekday_count <= io_wdata_in[WEEKDAY_W-1:0];
    end else if (advance) begin
      weekday_count <= next_weekday[WEEKDAY_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (count_wr && (io_addr_in == OFS_MONTH_DAY)) begin
      day_of_month_count <= io_wdata_in;
    end else if (advance) begin
      day_of_month_count <= next_month_day;
    end
  end

  // month steps on day wrap
  always_ff @(posedge clk_in) begin
    if (count_wr && (io_addr_in == OFS_PERIOD)) begin
      period_of_year_count <= io_wdata_in;
    end else if (advance && wrap_month_day) begin
      period_of_year_count <= next_period;
    end
  end

  // year steps on month wrap
  always_ff @(posedge clk_in) begin
    if (count_wr && (io_addr_in == OFS_YEAR)) begin
      year_count <= io_wdata_in;
    end else if (advance && wrap_month_day && wrap_period) begin
      year_count <= next_year;
    end
  end

  // century steps on year wrap
  always_ff @(posedge clk_in) begin
    if (count_wr && (io_addr_in == OFS_HUNDRED)) begin
      hundred_year_count <= io_wdata_in;
    end else if (advance && wrap_month_day && wrap_period && wrap_year) begin
      hundred_year_count <= next_hundred;
    end
  end

  // ------------------------------------------------------------
  // alarm set-points; ranges are the writer's concern
  // ------------------------------------------------------------
  // alarm writes always taken
  always_ff @(posedge clk_in) begin
    if (io_wr_in && (io_addr_in == OFS_ALM_SEC)) begin
      alarm_second_value <= io_wdata_in;
    end
    if (io_wr_in && (io_addr_in == OFS_ALM_MIN)) begin
      alarm_minute_value <= io_wdata_in;
    end
    if (io_wr_in && (io_addr_in == OFS_ALM_HOUR)) begin
      alarm_hour_value <= io_wdata_in;
    end
  end

  // ------------------------------------------------------------
  // read path: registered, answer one edge after the strobe
  // ------------------------------------------------------------
  // values read in stored coding
  always_comb begin
    unique case (io_addr_in)
      OFS_WEEKDAY: next_rdata = {RESERVED_NIBBLE, weekday_count};
      OFS_MONTH_DAY: next_rdata = day_of_month_count;
      OFS_PERIOD: next_rdata = period_of_year_count;
      OFS_YEAR: next_rdata = year_count;
      OFS_HUNDRED: next_rdata = hundred_year_count;
      OFS_ALM_SEC: next_rdata = alarm_second_value;
      OFS_ALM_MIN: next_rdata = alarm_minute_value;
      OFS_ALM_HOUR: next_rdata = alarm_hour_value;
      default: next_rdata = UNMAPPED_READ;
    endcase
  end

  // data holds between reads so a slow reader sees a steady value
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      io_rdata_out <= UNMAPPED_READ;
    end else if (io_rd_in) begin
      io_rdata_out <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // alarm compare
  // ------------------------------------------------------------
  // all enabled fields
  rcar_match u_match (
    .enable_in(alarm_enable_in),
    .sec_now_in(cur_second_in),
    .sec_set_in(alarm_second_value),
    .min_now_in(cur_minute_in),
    .min_set_in(alarm_minute_value),
    .hour_now_in(cur_hour_in),
    .hour_set_in(alarm_hour_value),
    .weekday_now_in(weekday_count),
    .weekday_set_in(alarm_weekday_in),
    .hit_out(alarm_hit)
  );

  // compare per second
  // a forced compare covers the relock case, where no tick may follow soon
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alarm_match_out <= MATCH_RESET[0];
    end else begin
      alarm_match_out <= (second_tick_in || force_compare_in) && alarm_hit;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_weekday_upper_zero: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    io_rd_in && (io_addr_in == OFS_WEEKDAY) |=> io_rdata_out[7:4] == 4'h0
  ) else $error("weekday upper nibble not zero");

  a_read_month_value: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    io_rd_in && (io_addr_in == OFS_PERIOD) |=> io_rdata_out == $past(period_of_year_count)
  ) else $error("month read returned wrong value");

  a_locked_write_dropped: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    io_wr_in && !count_unlock_in && (io_addr_in == OFS_MONTH_DAY) && !day_roll_in
    |=> $stable(day_of_month_count)
  ) else $error("locked write changed day count");

  a_unlocked_write_kept: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    io_wr_in && count_unlock_in && (io_addr_in == OFS_YEAR)
    |=> year_count == $past(io_wdata_in)
  ) else $error("unlocked write not stored");

  a_alarm_write_always: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    io_wr_in && !count_unlock_in && (io_addr_in == OFS_ALM_HOUR)
    |=> alarm_hour_value == $past(io_wdata_in)
  ) else $error("alarm write lost while locked");

  a_unlocked_frozen: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    count_unlock_in && day_roll_in && !io_wr_in |=> $stable(day_of_month_count)
  ) else $error("calendar advanced while unlocked");

  a_weekday_wraps_one: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    advance && (weekday_count == 4'h7) |=> weekday_count == 4'h1
  ) else $error("weekday did not wrap to one");

  a_bcd_digit_carry: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    advance && bcd_mode_in && (day_of_month_count == 8'h19) |=> day_of_month_count == 8'h20
  ) else $error("bcd day did not carry");

  a_month_from_one: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    advance && !bcd_mode_in && (day_of_month_count == 8'h1f) && (period_of_year_count == 8'h0c)
    |=> (day_of_month_count == 8'h01) && (period_of_year_count == 8'h01)
  ) else $error("day or month did not restart at one");

  a_match_seconds_only: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    second_tick_in && (alarm_enable_in == 4'h1) && (cur_second_in == alarm_second_value)
    |=> alarm_match_out
  ) else $error("seconds match did not raise alarm");

  a_match_needs_fields: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    alarm_match_out |-> (!$past(alarm_enable_in[EN_HOUR])
      || ($past(cur_hour_in) == $past(alarm_hour_value)))
  ) else $error("alarm raised on hour mismatch");

  a_match_on_tick: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !second_tick_in && !force_compare_in |=> !alarm_match_out
  ) else $error("alarm raised without compare");

  a_bcd_year_wrap: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    advance && bcd_mode_in && (day_of_month_count == 8'h31) && (period_of_year_count == 8'h12)
    && (year_count == 8'h99) |=> year_count == 8'h00
  ) else $error("bcd year did not wrap to zero");

  a_unlocked_weekday_hold: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    count_unlock_in && day_roll_in && !io_wr_in
    |=> $stable(weekday_count)
  ) else $error("weekday advanced while unlocked");

  a_alarm_sec_always: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    io_wr_in && !count_unlock_in && (io_addr_in == OFS_ALM_SEC)
    |=> alarm_second_value == $past(io_wdata_in)
  ) else $error("alarm seconds write lost while locked");

endmodule
`default_nettype wire

// *** bench/tb.sv ***
// testbench for the calendar and alarm register block
// assumes rcar_top alone; the bench plays cpu bus, control bits and time-of-day counters
`timescale 1ns/1ps
`default_nettype none
module tb import rcar_pkg::*;;
  // ----------------------------------------
  // clock, reset and stimulus nets
  // ----------------------------------------
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic unlock = 1'b0;
  logic bcd = 1'b0;
  logic roll = 1'b0;
  logic tick = 1'b0;
  logic force_cmp = 1'b0;
  logic [3:0] en = 4'h0;
  logic [7:0] cur_s = 8'h00;
  logic [7:0] cur_m = 8'h00;
  logic [7:0] cur_h = 8'h00;
  logic [3:0] alm_wd = 4'h0;
  logic match;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  // 25 MHz clock
  always #20 clk_in = ~clk_in;

  rcar_top rcar_top_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .io_addr_in(addr), .io_wdata_in(wdata),
    .io_wr_in(wr), .io_rd_in(rd), .io_rdata_out(rdata), .count_unlock_in(unlock),
    .bcd_mode_in(bcd), .day_roll_in(roll), .second_tick_in(tick),
    .force_compare_in(force_cmp), .alarm_enable_in(en), .cur_second_in(cur_s),
    .cur_minute_in(cur_m), .cur_hour_in(cur_h), .alarm_weekday_in(alm_wd),
    .alarm_match_out(match)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle strobes, all changes on the falling edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask

  // read data is registered at the strobe edge, so it is settled at the next falling edge
  task automatic exp_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    check(name, rdata, exp);
  endtask

  // load all five counts while unlocked, then lock again
  task automatic load_counts(input logic [7:0] w, d, m, y, c);
    unlock = 1'b1;
    wr_reg(OFS_WEEKDAY, w);
    wr_reg(OFS_MONTH_DAY, d);
    wr_reg(OFS_PERIOD, m);
    wr_reg(OFS_YEAR, y);
    wr_reg(OFS_HUNDRED, c);
    @(negedge clk_in);
    unlock = 1'b0;
  endtask

  task automatic day_roll();
    @(negedge clk_in);
    roll = 1'b1;
    @(negedge clk_in);
    roll = 1'b0;
  endtask

  // fire a compare and look at the one-cycle answer and its end
  task automatic compare(input logic by_force, input logic exp);
    @(negedge clk_in);
    if (by_force) force_cmp = 1'b1;
    else tick = 1'b1;
    @(negedge clk_in);
    force_cmp = 1'b0;
    tick = 1'b0;
    check("alarm_match", {7'h00, match}, {7'h00, exp});
    @(negedge clk_in);
    check("alarm_match_end", {7'h00, match}, 8'h00);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // locked and unlocked access
  task automatic t_access();
    load_counts(8'hff, 8'h05, 8'h06, 8'h07, 8'h08);
    exp_reg("weekday", OFS_WEEKDAY, 8'h0f);
    exp_reg("month_day", OFS_MONTH_DAY, 8'h05);
    wr_reg(OFS_WEEKDAY, 8'h02);
    wr_reg(OFS_MONTH_DAY, 8'h11);
    wr_reg(OFS_PERIOD, 8'h0a);
    wr_reg(OFS_YEAR, 8'h21);
    wr_reg(OFS_HUNDRED, 8'h13);
    exp_reg("weekday_locked", OFS_WEEKDAY, 8'h0f);
    exp_reg("day_locked", OFS_MONTH_DAY, 8'h05);
    exp_reg("period_locked", OFS_PERIOD, 8'h06);
    exp_reg("year_locked", OFS_YEAR, 8'h07);
    exp_reg("hundred_locked", OFS_HUNDRED, 8'h08);
    wr_reg(OFS_ALM_SEC, 8'h2a);
    wr_reg(OFS_ALM_MIN, 8'h3b);
    wr_reg(OFS_ALM_HOUR, 8'h3f);
    exp_reg("alarm_sec", OFS_ALM_SEC, 8'h2a);
    exp_reg("alarm_min", OFS_ALM_MIN, 8'h3b);
    exp_reg("alarm_hour", OFS_ALM_HOUR, 8'h3f);
    exp_reg("unmapped", 8'hf0, UNMAPPED_READ);
    $display("test access done");
  endtask

  task automatic t_reset();
    @(negedge clk_in);
    nrst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check("rdata_in_reset", rdata, 8'h00);
    nrst_in = 1'b1;
    exp_reg("weekday_kept", OFS_WEEKDAY, 8'h0f);
    exp_reg("year_kept", OFS_YEAR, 8'h07);
    exp_reg("alarm_hour_kept", OFS_ALM_HOUR, 8'h3f);
    $display("test reset done");
  endtask

  task automatic t_roll_bin();
    bcd = 1'b0;
    load_counts(8'h07, 8'h1f, 8'h0c, 8'h63, 8'h05);
    day_roll();
    exp_reg("weekday_wrap", OFS_WEEKDAY, 8'h01);
    exp_reg("day_wrap", OFS_MONTH_DAY, 8'h01);
    exp_reg("period_wrap", OFS_PERIOD, 8'h01);
    exp_reg("year_wrap", OFS_YEAR, 8'h00);
    exp_reg("hundred_carry", OFS_HUNDRED, 8'h06);
    load_counts(8'h03, 8'h09, 8'h04, 8'h10, 8'h05);
    day_roll();
    exp_reg("day_bin_step", OFS_MONTH_DAY, 8'h0a);
    exp_reg("period_no_carry", OFS_PERIOD, 8'h04);
    unlock = 1'b1;
    day_roll();
    exp_reg("day_frozen", OFS_MONTH_DAY, 8'h0a);
    unlock = 1'b0;
    day_roll();
    exp_reg("day_resumed", OFS_MONTH_DAY, 8'h0b);
    $display("test binary roll done");
  endtask

  task automatic t_roll_bcd();
    bcd = 1'b1;
    load_counts(8'h03, 8'h31, 8'h12, 8'h99, 8'h19);
    day_roll();
    exp_reg("weekday_bcd", OFS_WEEKDAY, 8'h04);
    exp_reg("day_bcd_wrap", OFS_MONTH_DAY, 8'h01);
    exp_reg("period_bcd_wrap", OFS_PERIOD, 8'h01);
    exp_reg("year_bcd_wrap", OFS_YEAR, 8'h00);
    exp_reg("hundred_bcd", OFS_HUNDRED, 8'h20);
    load_counts(8'h04, 8'h19, 8'h09, 8'h49, 8'h20);
    day_roll();
    exp_reg("day_bcd_carry", OFS_MONTH_DAY, 8'h20);
    exp_reg("period_bcd_hold", OFS_PERIOD, 8'h09);
    $display("test bcd roll done");
  endtask

  task automatic t_alarm();
    wr_reg(OFS_ALM_SEC, 8'h2a);
    wr_reg(OFS_ALM_MIN, 8'h15);
    wr_reg(OFS_ALM_HOUR, 8'h07);
    cur_s = 8'h2a;
    cur_m = 8'h14;
    cur_h = 8'h07;
    en = 4'b0001;
    compare(1'b0, 1'b1);
    repeat (3) @(negedge clk_in);
    check("no_tick_no_alarm", {7'h00, match}, 8'h00);
    en = 4'b0011;
    compare(1'b0, 1'b0);
    cur_m = 8'h15;
    compare(1'b0, 1'b1);
    en = 4'b0000;
    compare(1'b0, 1'b0);
    en = 4'b1000;
    // the last bcd roll left the weekday count at five
    alm_wd = 4'h5;
    compare(1'b1, 1'b1);
    alm_wd = 4'h4;
    compare(1'b1, 1'b0);
    en = 4'b0111;
    cur_h = 8'h08;
    compare(1'b0, 1'b0);
    cur_h = 8'h07;
    compare(1'b0, 1'b1);
    $display("test alarm done");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // the whole run takes under two hundred cycles; a hang is cut well beyond that
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    repeat (3) @(negedge clk_in);
    nrst_in = 1'b1;
    t_access();
    t_reset();
    t_roll_bin();
    t_roll_bcd();
    t_alarm();
    results();
  end
endmodule
`default_nettype wire
